/* verilog/rdmwc_pkg.sv */
// ---------------------------------------------------------------------------
// Shared constants for the receive DMA write command selection
// ---------------------------------------------------------------------------
package rdmwc_pkg;

    // Configuration space offsets (byte addresses)
    localparam logic [7:0] CFG_CMD_OFS = 8'h04; // Command register
    localparam logic [7:0] CFG_CLS_OFS = 8'h0C; // Cache line size register

    // Command register field position
    localparam int CMD_MWI_BIT = 4; // Invalidate enable bit

    // Reset values
    localparam logic [7:0] CLS_RESET = 8'h00; // Cache line size after reset
    localparam logic MWI_EN_RESET = 1'b0;    // Invalidate disabled after reset

    // Cache line sizes in doublewords that allow invalidate bursts
    localparam logic [7:0] CLS_SMALL = 8'h08;
    localparam logic [7:0] CLS_LARGE = 8'h10;

    // Bus command codes
    localparam logic [3:0] BUS_CMD_MW = 4'h7;  // Memory write
    localparam logic [3:0] BUS_CMD_MWI = 4'hF; // Memory write and invalidate
    localparam logic [3:0] BUS_CMD_DAC = 4'hD; // Dual address cycle

    // Byte enables, active low, all lanes on
    localparam logic [3:0] BE_ALL_N = 4'h0;

    // Address step per doubleword transfer
    localparam logic [63:0] ADDR_STEP = 64'h0000_0000_0000_0004;

    // Master state machine, Gray coded from ST_IDLE to ST_TURN along the dual address path
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_REQ = 3'h1,
        ST_ADLO = 3'h3,
        ST_ADHI = 3'h2,
        ST_DATA = 3'h6,
        ST_TURN = 3'h7
    } rdmwc_state_t;

endpackage

/* verilog/rdmwc_cmd_sel.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Burst command and length decision
// ---------------------------------------------------------------------------
module rdmwc_cmd_sel #(
    parameter int LEN_W = 16,
    parameter int LVL_W = 7
) (
    input wire logic [7:0] i_cls,
    input wire logic i_mwi_en,
    input wire logic [5:0] i_addr_lo,
    input wire logic [LEN_W-1:0] i_total,
    input wire logic [LVL_W-1:0] i_level,
    output logic o_use_mwi,
    output logic [LEN_W-1:0] o_len
);

    logic cls_ok;            // Line size is one of the two usable values
    logic [7:0] offs;        // Doubleword offset inside the line
    logic [LEN_W-1:0] to_bnd; // Doublewords up to the next line boundary
    logic [LEN_W-1:0] lvl;   // Data available, widened
    logic [LEN_W-1:0] cls_w; // Line size, widened
    logic [LEN_W-1:0] len;   // Plain write length

    // Decide command and burst length from the current conditions
    always_comb begin
        cls_ok = (i_cls == rdmwc_pkg::CLS_SMALL) || (i_cls == rdmwc_pkg::CLS_LARGE);
        if (i_cls == rdmwc_pkg::CLS_LARGE) begin
            offs = {4'h0, i_addr_lo[5:2]};
        end else begin
            offs = {5'h00, i_addr_lo[4:2]};
        end
        cls_w = LEN_W'(i_cls);
        to_bnd = cls_w - LEN_W'(offs);
        lvl = LEN_W'(i_level);
        // All four conditions plus enough work left for a whole line
        o_use_mwi = cls_ok && i_mwi_en && (offs == 8'h00) && (lvl >= cls_w) && (i_total >= cls_w);
        len = i_total;
        if (lvl < len) begin
            len = lvl;
        end
        // Partial lines stop at the boundary so the next burst can be aligned
        if (cls_ok && (to_bnd < len)) begin
            len = to_bnd;
        end
        o_len = o_use_mwi ? cls_w : len;
    end

endmodule

/* verilog/rdmwc_rx_dma_wr.sv */
`timescale 1ns/1ps
module rdmwc_rx_dma_wr #(
    parameter int LEN_W = 16,
    parameter int LVL_W = 7
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // Configuration space access
    input wire logic i_cfg_wr,
    input wire logic i_cfg_rd,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [3:0] i_cfg_be,
    input wire logic [31:0] i_cfg_wdata,
    output logic [31:0] o_cfg_rdata,
    // Receive DMA request
    input wire logic i_dma_start,
    input wire logic [63:0] i_dma_addr,
    input wire logic [LEN_W-1:0] i_dma_len,
    output logic o_dma_ready,
    output logic o_dma_done,
    // Receive FIFO, show-ahead
    input wire logic [31:0] i_fifo_data,
    input wire logic [LVL_W-1:0] i_fifo_level,
    output logic o_fifo_pop,
    // Bus master pins
    output logic o_req_n,
    input wire logic i_gnt_n,
    output logic [31:0] o_ad,
    output logic o_ad_oe_n,
    output logic [3:0] o_cbe_n,
    output logic o_cbe_oe_n,
    output logic o_frame_n,
    output logic o_frame_oe_n,
    output logic o_irdy_n,
    output logic o_irdy_oe_n,
    input wire logic i_trdy_n,
    input wire logic i_stop_n
);

    // -----------------------------------------------------------------------
    // Configuration registers
    // -----------------------------------------------------------------------
    logic [7:0] cls_q, cls_d;         // Cache line size in doublewords
    logic mwi_en_q, mwi_en_d;         // Invalidate enable
    logic [31:0] rdata_q, rdata_d;    // Read data

    // Decode writes and reads
    always_comb begin
        cls_d = cls_q;
        mwi_en_d = mwi_en_q;
        rdata_d = rdata_q;
        if (i_cfg_wr && i_cfg_be[0]) begin
            if (i_cfg_addr == rdmwc_pkg::CFG_CLS_OFS) begin
                cls_d = i_cfg_wdata[7:0];
            end else if (i_cfg_addr == rdmwc_pkg::CFG_CMD_OFS) begin
                mwi_en_d = i_cfg_wdata[rdmwc_pkg::CMD_MWI_BIT];
            end
        end
        if (i_cfg_rd) begin
            if (i_cfg_addr == rdmwc_pkg::CFG_CLS_OFS) begin
                rdata_d = {24'h00_0000, cls_q};
            end else if (i_cfg_addr == rdmwc_pkg::CFG_CMD_OFS) begin
                rdata_d = 32'(mwi_en_q) << rdmwc_pkg::CMD_MWI_BIT;
            end else begin
                rdata_d = 32'h0000_0000; // Unmapped offsets read zero
            end
        end
    end

    // Register configuration state
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cls_q <= rdmwc_pkg::CLS_RESET;
            mwi_en_q <= rdmwc_pkg::MWI_EN_RESET;
            rdata_q <= 32'h0000_0000;
        end else begin
            cls_q <= cls_d;
            mwi_en_q <= mwi_en_d;
            rdata_q <= rdata_d;
        end
    end

    assign o_cfg_rdata = rdata_q;

    // -----------------------------------------------------------------------
    // Burst decision
    // -----------------------------------------------------------------------
    logic held_q, held_d;              // Data word loaded but not yet sent
    logic [31:0] hdata_q, hdata_d;     // Word kept for resend after a stop
    logic [LEN_W-1:0] remld_q, remld_d; // Words not yet taken from the FIFO
    logic [63:0] addr_q, addr_d;       // Address of next transfer
    logic [LEN_W-1:0] total;           // Words still owed to memory
    logic [LVL_W-1:0] eff_level;       // FIFO words plus the held word
    logic sel_mwi;                     // Invalidate allowed for next burst
    logic [LEN_W-1:0] sel_len;         // Length of next burst

    assign total = remld_q + LEN_W'(held_q);
    assign eff_level = i_fifo_level + LVL_W'(held_q);

    rdmwc_cmd_sel #(
        .LEN_W(LEN_W),
        .LVL_W(LVL_W)
    ) u_sel (
        .i_cls(cls_q),
        .i_mwi_en(mwi_en_q),
        .i_addr_lo(addr_q[5:0]),
        .i_total(total),
        .i_level(eff_level),
        .o_use_mwi(sel_mwi),
        .o_len(sel_len)
    );

    // -----------------------------------------------------------------------
    // Master state machine
    // -----------------------------------------------------------------------
    rdmwc_pkg::rdmwc_state_t state_q, state_d;
    logic [LEN_W-1:0] cnt_q, cnt_d;    // Words of burst still to load
    logic mwi_q, mwi_d;                // Current burst uses invalidate
    logic dac_q, dac_d;                // Current burst needs two address phases
    logic [3:0] cmd_q, cmd_d;          // Current burst command
    logic [7:0] bcls_q, bcls_d;        // Line size the burst started with
    logic [31:0] ad_q, ad_d;
    logic ad_oe_n_q, ad_oe_n_d;
    logic [3:0] cbe_q, cbe_d;
    logic cbe_oe_n_q, cbe_oe_n_d;
    logic frame_n_q, frame_n_d;
    logic frame_oe_n_q, frame_oe_n_d;
    logic irdy_n_q, irdy_n_d;
    logic irdy_oe_n_q, irdy_oe_n_d;
    logic req_n_q, req_n_d;
    logic done_q, done_d;
    logic pop;                         // Take head word from the FIFO
    logic xfer;                        // Data phase completes this cycle
    logic cont;                        // Next line may follow in this burst

    // Next values for the bus master
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        mwi_d = mwi_q;
        dac_d = dac_q;
        cmd_d = cmd_q;
        bcls_d = bcls_q;
        ad_d = ad_q;
        ad_oe_n_d = ad_oe_n_q;
        cbe_d = cbe_q;
        cbe_oe_n_d = cbe_oe_n_q;
        frame_n_d = frame_n_q;
        frame_oe_n_d = frame_oe_n_q;
        irdy_n_d = irdy_n_q;
        irdy_oe_n_d = irdy_oe_n_q;
        req_n_d = req_n_q;
        done_d = 1'b0;
        held_d = held_q;
        hdata_d = hdata_q;
        remld_d = remld_q;
        addr_d = addr_q;
        pop = 1'b0;
        xfer = 1'b0;
        // All conditions must still hold for a whole further line
        cont = mwi_en_q && (cls_q == bcls_q) && (remld_q > LEN_W'(cls_q))
            && (LEN_W'(i_fifo_level) > LEN_W'(cls_q));
        case (state_q)
            rdmwc_pkg::ST_IDLE: begin
                ad_oe_n_d = 1'b1;
                cbe_oe_n_d = 1'b1;
                frame_oe_n_d = 1'b1;
                irdy_oe_n_d = 1'b1;
                // New buffer only when nothing is pending
                if (i_dma_start && (total == '0)) begin
                    addr_d = i_dma_addr;
                    remld_d = i_dma_len;
                end else if ((total != '0) && (eff_level != '0)) begin
                    req_n_d = 1'b0;
                    state_d = rdmwc_pkg::ST_REQ;
                end
            end
            rdmwc_pkg::ST_REQ: begin
                if (!i_gnt_n) begin
                    // Command fixed from conditions at the first address phase
                    mwi_d = sel_mwi;
                    cmd_d = sel_mwi ? rdmwc_pkg::BUS_CMD_MWI : rdmwc_pkg::BUS_CMD_MW;
                    cnt_d = sel_len;
                    bcls_d = cls_q;
                    dac_d = (addr_q[63:32] != 32'h0000_0000);
                    ad_d = addr_q[31:0];
                    cbe_d = (addr_q[63:32] != 32'h0000_0000) ? rdmwc_pkg::BUS_CMD_DAC
                        : (sel_mwi ? rdmwc_pkg::BUS_CMD_MWI : rdmwc_pkg::BUS_CMD_MW);
                    ad_oe_n_d = 1'b0;
                    cbe_oe_n_d = 1'b0;
                    frame_n_d = 1'b0;
                    frame_oe_n_d = 1'b0;
                    irdy_n_d = 1'b1;
                    irdy_oe_n_d = 1'b0;
                    req_n_d = 1'b1;
                    state_d = rdmwc_pkg::ST_ADLO;
                end
            end
            rdmwc_pkg::ST_ADLO, rdmwc_pkg::ST_ADHI: begin
                if ((state_q == rdmwc_pkg::ST_ADLO) && dac_q) begin
                    ad_d = addr_q[63:32];
                    cbe_d = cmd_q;
                    state_d = rdmwc_pkg::ST_ADHI;
                end else begin
                    // First data word: the held word wins over the FIFO
                    if (!held_q) begin
                        ad_d = i_fifo_data;
                        pop = 1'b1;
                        remld_d = remld_q - LEN_W'(1);
                    end else begin
                        ad_d = hdata_q;
                    end
                    held_d = 1'b0;
                    cnt_d = cnt_q - LEN_W'(1);
                    frame_n_d = (cnt_q == LEN_W'(1));
                    cbe_d = rdmwc_pkg::BE_ALL_N;
                    irdy_n_d = 1'b0;
                    state_d = rdmwc_pkg::ST_DATA;
                end
            end
            rdmwc_pkg::ST_DATA: begin
                xfer = !i_trdy_n;
                if (xfer) begin
                    addr_d = addr_q + rdmwc_pkg::ADDR_STEP;
                end
                if (xfer && !frame_n_q && i_stop_n) begin
                    // Load the next word while the burst goes on
                    ad_d = i_fifo_data;
                    pop = 1'b1;
                    remld_d = remld_q - LEN_W'(1);
                    if (mwi_q && (cnt_q == LEN_W'(1)) && cont) begin
                        cnt_d = LEN_W'(bcls_q);
                        frame_n_d = 1'b0;
                    end else begin
                        cnt_d = cnt_q - LEN_W'(1);
                        frame_n_d = (cnt_q == LEN_W'(1));
                    end
                end else if (xfer || !i_stop_n) begin
                    // Last phase done or target termination accepted
                    held_d = !xfer;
                    hdata_d = ad_q;
                    frame_n_d = 1'b1;
                    irdy_n_d = 1'b1;
                    state_d = rdmwc_pkg::ST_TURN;
                end
            end
            rdmwc_pkg::ST_TURN: begin
                ad_oe_n_d = 1'b1;
                cbe_oe_n_d = 1'b1;
                frame_oe_n_d = 1'b1;
                irdy_oe_n_d = 1'b1;
                done_d = (total == '0);
                state_d = rdmwc_pkg::ST_IDLE;
            end
            default: begin
                state_d = rdmwc_pkg::ST_IDLE;
            end
        endcase
    end

    // Register bus master state
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= rdmwc_pkg::ST_IDLE;
            cnt_q <= '0;
            mwi_q <= 1'b0;
            dac_q <= 1'b0;
            cmd_q <= rdmwc_pkg::BUS_CMD_MW;
            bcls_q <= rdmwc_pkg::CLS_RESET;
            ad_q <= 32'h0000_0000;
            ad_oe_n_q <= 1'b1;
            cbe_q <= rdmwc_pkg::BE_ALL_N;
            cbe_oe_n_q <= 1'b1;
            frame_n_q <= 1'b1;
            frame_oe_n_q <= 1'b1;
            irdy_n_q <= 1'b1;
            irdy_oe_n_q <= 1'b1;
            req_n_q <= 1'b1;
            done_q <= 1'b0;
            held_q <= 1'b0;
            hdata_q <= 32'h0000_0000;
            remld_q <= '0;
            addr_q <= 64'h0000_0000_0000_0000;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            mwi_q <= mwi_d;
            dac_q <= dac_d;
            cmd_q <= cmd_d;
            bcls_q <= bcls_d;
            ad_q <= ad_d;
            ad_oe_n_q <= ad_oe_n_d;
            cbe_q <= cbe_d;
            cbe_oe_n_q <= cbe_oe_n_d;
            frame_n_q <= frame_n_d;
            frame_oe_n_q <= frame_oe_n_d;
            irdy_n_q <= irdy_n_d;
            irdy_oe_n_q <= irdy_oe_n_d;
            req_n_q <= req_n_d;
            done_q <= done_d;
            held_q <= held_d;
            hdata_q <= hdata_d;
            remld_q <= remld_d;
            addr_q <= addr_d;
        end
    end

    // -----------------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------------
    assign o_fifo_pop = pop;
    assign o_dma_ready = (state_q == rdmwc_pkg::ST_IDLE) && (total == '0);
    assign o_dma_done = done_q;
    assign o_req_n = req_n_q;
    assign o_ad = ad_q;
    assign o_ad_oe_n = ad_oe_n_q;
    assign o_cbe_n = cbe_q;
    assign o_cbe_oe_n = cbe_oe_n_q;
    assign o_frame_n = frame_n_q;
    assign o_frame_oe_n = frame_oe_n_q;
    assign o_irdy_n = irdy_n_q;
    assign o_irdy_oe_n = irdy_oe_n_q;

endmodule

/* dv/rdmwc_rx_dma_wr_sva.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bus master command checks
// ------------------------------------------------------------
module rdmwc_rx_dma_wr_sva (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_cfg_wr,
    input wire logic i_cfg_rd,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [3:0] i_cfg_be,
    input wire logic [31:0] i_cfg_wdata,
    input wire logic [31:0] o_cfg_rdata,
    input wire logic o_dma_ready,
    input wire logic o_dma_done,
    input wire logic [31:0] o_ad,
    input wire logic [3:0] o_cbe_n,
    input wire logic o_frame_n,
    input wire logic o_frame_oe_n,
    input wire logic o_irdy_n,
    input wire logic i_trdy_n,
    input wire logic i_stop_n
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    logic [7:0] cls_q; // Shadow line size
    logic en_q; // Shadow invalidate enable
    logic fr_q; // Frame one cycle back
    logic dac_q; // Upper address phase now
    logic stop_q; // Target stop seen in burst
    logic [3:0] cmd_q; // Command of current burst
    logic [15:0] cnt_q; // Data transfers in burst
    logic addr_ph; // First address phase
    assign addr_ph = !o_frame_n && fr_q && !o_frame_oe_n;
    // Shadow config and burst tracking
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cls_q <= rdmwc_pkg::CLS_RESET;
            en_q <= rdmwc_pkg::MWI_EN_RESET;
            fr_q <= 1'b1;
            dac_q <= 1'b0;
            stop_q <= 1'b0;
            cmd_q <= rdmwc_pkg::BUS_CMD_MW;
            cnt_q <= 16'h0000;
        end else begin
            fr_q <= o_frame_n;
            if (i_cfg_wr && i_cfg_be[0] && i_cfg_addr == rdmwc_pkg::CFG_CLS_OFS) cls_q <= i_cfg_wdata[7:0];
            if (i_cfg_wr && i_cfg_be[0] && i_cfg_addr == rdmwc_pkg::CFG_CMD_OFS) en_q <= i_cfg_wdata[4];
            dac_q <= addr_ph && o_cbe_n == rdmwc_pkg::BUS_CMD_DAC;
            if (addr_ph || dac_q) cmd_q <= o_cbe_n;
            if (addr_ph) begin
                cnt_q <= 16'h0000;
                stop_q <= 1'b0;
            end else begin
                if (!o_irdy_n && !i_trdy_n) cnt_q <= cnt_q + 16'h0001;
                if (!o_irdy_n && !i_stop_n) stop_q <= 1'b1;
            end
        end
    end
    a_mwi_all_be: assert property (!o_irdy_n && cmd_q == rdmwc_pkg::BUS_CMD_MWI |-> o_cbe_n == 4'h0)
        else $error("invalidate data phase without all byte enables");
    a_mwi_min_line: assert property ($rose(o_irdy_n) && cmd_q == 4'hF && !stop_q
        |-> cnt_q >= {8'h00, cls_q})
        else $error("invalidate burst shorter than a line");
    a_mwi_line_end: assert property ($rose(o_irdy_n) && cmd_q == 4'hF && !stop_q
        |-> (cnt_q[7:0] & (cls_q - 8'h01)) == 8'h00)
        else $error("invalidate burst not ended on a line boundary");
    a_mwi_needs_en: assert property ((addr_ph || dac_q) && o_cbe_n == rdmwc_pkg::BUS_CMD_MWI |-> en_q)
        else $error("invalidate issued while disabled");
    a_mwi_line_size: assert property ((addr_ph || dac_q) && o_cbe_n == 4'hF
        |-> cls_q == 8'h08 || cls_q == 8'h10)
        else $error("invalidate issued with unsupported line size");
    a_mwi_aligned: assert property (addr_ph && o_cbe_n == 4'hF
        |-> (o_ad[9:0] & ({cls_q, 2'b00} - 10'h001)) == 10'h000)
        else $error("invalidate start address not line aligned");
    a_dac_upper: assert property (addr_ph && o_cbe_n == 4'hD
        |=> !o_frame_n && o_ad != 32'h0000_0000 && o_cbe_n != 4'hD)
        else $error("dual address cycle lacks upper address phase");
    a_cls_readback: assert property (i_cfg_rd && i_cfg_addr == 8'h0C
        |=> o_cfg_rdata == {24'h00_0000, cls_q})
        else $error("line size read back wrong");
    a_done_idle: assert property (o_dma_done |-> o_dma_ready && o_frame_oe_n ##1 !o_dma_done)
        else $error("done pulse malformed");
    c_mwi: cover property (addr_ph && o_cbe_n == 4'hF);
    c_dac: cover property (addr_ph && o_cbe_n == 4'hD);
    c_done: cover property (o_dma_done);
    c_stop: cover property (!o_irdy_n && !i_stop_n);
endmodule

/* dv/rdmwc_pci_tgt.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Target memory and arbiter model
// ------------------------------------------------------------
module rdmwc_pci_tgt (
    input wire logic i_clk,
    input wire logic i_slow,
    input wire logic i_clr,
    input wire logic i_stop,
    input wire logic i_req_n,
    input wire logic i_frame_n,
    input wire logic i_irdy_n,
    input wire logic [3:0] i_cbe_n,
    input wire logic [31:0] i_ad,
    output logic o_gnt_n,
    output logic o_trdy_n,
    output logic o_stop_n,
    output logic [7:0] o_bursts,
    output logic [7:0] o_mwi,
    output logic [7:0] o_words,
    output logic o_be_bad,
    output logic [63:0] o_addr,
    output logic [31:0] o_last
);
    logic fr_q = 1'b1; // Frame one cycle back
    logic dac_q = 1'b0; // Upper address phase now
    logic tog_q = 1'b0; // Wait state toggle
    logic [3:0] cmd_q = 4'h7; // Command of current burst
    logic stp; // Stop without ready on the eighth word of the first burst
    assign stp = i_stop && !i_irdy_n && o_bursts == 8'h01 && o_words == 8'h07;
    // Ready held back every other cycle when slow, or while stopping
    assign o_trdy_n = !(!i_irdy_n && !(i_slow && tog_q)) || stp;
    assign o_stop_n = !stp;
    // Grant, address capture and data count
    always @(posedge i_clk) begin
        o_gnt_n <= i_req_n;
        fr_q <= i_frame_n;
        tog_q <= !tog_q;
        dac_q <= !i_frame_n && fr_q && i_cbe_n == 4'hD;
        if (i_clr) begin
            o_bursts <= 8'h00;
            o_mwi <= 8'h00;
            o_words <= 8'h00;
            o_be_bad <= 1'b0;
        end else if (!i_frame_n && fr_q) begin
            o_bursts <= o_bursts + 8'h01;
            o_addr <= {32'h0000_0000, i_ad};
            cmd_q <= i_cbe_n;
            if (i_cbe_n == 4'hF) o_mwi <= o_mwi + 8'h01;
        end else if (dac_q) begin
            o_addr[63:32] <= i_ad;
            cmd_q <= i_cbe_n;
            if (i_cbe_n == 4'hF) o_mwi <= o_mwi + 8'h01;
        end else if (!i_irdy_n && !o_trdy_n) begin
            o_words <= o_words + 8'h01;
            o_last <= i_ad;
            if (cmd_q == 4'hF && i_cbe_n != 4'h0) o_be_bad <= 1'b1;
        end
    end
endmodule

/* dv/rdmwc_rx_dma_wr_tb.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Receive DMA write command bench
// ------------------------------------------------------------
module rdmwc_rx_dma_wr_tb;
    logic i_core_clk, i_resetn, i_cfg_wr, i_cfg_rd, i_dma_start, i_gnt_n, i_trdy_n, i_stop_n;
    logic [7:0] i_cfg_addr, m_bursts, m_mwi, m_words;
    logic [3:0] i_cfg_be, o_cbe_n;
    logic [31:0] i_cfg_wdata, o_cfg_rdata, i_fifo_data, o_ad, m_last;
    logic [63:0] i_dma_addr, m_addr;
    logic [15:0] i_dma_len, idx, exp_idx;
    logic [6:0] i_fifo_level;
    logic o_dma_ready, o_dma_done, o_fifo_pop, o_req_n, o_ad_oe_n, o_cbe_oe_n, o_frame_n, o_frame_oe_n;
    logic o_irdy_n, o_irdy_oe_n, m_slow, m_clr, m_bad, m_stop;
    int n_errors, checked;
    rdmwc_rx_dma_wr rdmwc_rx_dma_wr_i (.*);
    rdmwc_pci_tgt rdmwc_pci_tgt_i (.i_clk(i_core_clk), .i_slow(m_slow), .i_clr(m_clr), .i_req_n(o_req_n),
        .i_frame_n(o_frame_n), .i_irdy_n(o_irdy_n), .i_cbe_n(o_cbe_n), .i_ad(o_ad), .o_gnt_n(i_gnt_n),
        .o_trdy_n(i_trdy_n), .o_stop_n(i_stop_n), .o_bursts(m_bursts), .o_mwi(m_mwi), .o_words(m_words),
        .o_be_bad(m_bad), .o_addr(m_addr), .o_last(m_last), .i_stop(m_stop));
    // Show-ahead FIFO: head word numbered by pops
    assign i_fifo_data = 32'hA000_0000 + {16'h0000, idx};
    always @(posedge i_core_clk) begin
        if (o_fifo_pop === 1'b1) begin
            idx <= idx + 16'h0001;
            i_fifo_level <= i_fifo_level - 7'h01;
        end
    end
    initial begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = !i_core_clk;
    end
    task tick;
        @(posedge i_core_clk);
        #1;
    endtask
    task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task cfg_wr(input logic [7:0] a, input logic [31:0] d);
        i_cfg_wr = 1'b1;
        i_cfg_addr = a;
        i_cfg_wdata = d;
        tick;
        i_cfg_wr = 1'b0;
    endtask
    task cfg_rd(input logic [7:0] a, input logic [31:0] e);
        i_cfg_rd = 1'b1;
        i_cfg_addr = a;
        tick;
        i_cfg_rd = 1'b0;
        chk("cfg_rdata", {32'h0000_0000, e}, {32'h0000_0000, o_cfg_rdata});
        tick;
    endtask
    // One buffer through the bus, then burst totals
    task run(input logic [63:0] a, input logic [15:0] n, input logic [6:0] lvl, input logic slow,
        input logic [7:0] b, input logic [7:0] mw, input logic [63:0] la);
        int k;
        i_fifo_level = lvl;
        m_slow = slow;
        m_clr = 1'b1;
        tick;
        m_clr = 1'b0;
        i_dma_start = 1'b1;
        i_dma_addr = a;
        i_dma_len = n;
        tick;
        i_dma_start = 1'b0;
        exp_idx = exp_idx + n;
        for (k = 0; k < 400 && o_dma_done !== 1'b1; k++) tick;
        chk("done", 64'h1, {63'h0, o_dma_done});
        tick;
        chk("bursts", {56'h0, b}, {56'h0, m_bursts});
        chk("mwi_bursts", {56'h0, mw}, {56'h0, m_mwi});
        chk("words", {48'h0, n}, {56'h0, m_words});
        chk("last_addr", la, m_addr);
        chk("be_bad", 64'h0, {63'h0, m_bad});
        chk("last_word", {32'h0, 32'hA000_0000 + {16'h0000, exp_idx} - 32'h0000_0001}, {32'h0, m_last});
    endtask
    task t_cfg;
        cfg_wr(8'h0C, 32'h0000_0010);
        cfg_rd(8'h0C, 32'h0000_0010);
        cfg_wr(8'h04, 32'h0000_0010);
        cfg_rd(8'h04, 32'h0000_0010);
        cfg_rd(8'h08, 32'h0000_0000);
    endtask
    task t_lines;
        cfg_wr(8'h0C, 32'h0000_0008);
        run(64'h0000_0000_0000_1000, 16'h0008, 7'h08, 1'b0, 8'h01, 8'h01, 64'h0000_0000_0000_1000);
        cfg_wr(8'h0C, 32'h0000_0010);
        run(64'h0000_0000_0000_2000, 16'h0010, 7'h10, 1'b1, 8'h01, 8'h01, 64'h0000_0000_0000_2000);
        cfg_wr(8'h0C, 32'h0000_0004);
        run(64'h0000_0000_0000_3000, 16'h0008, 7'h08, 1'b0, 8'h01, 8'h00, 64'h0000_0000_0000_3000);
    endtask
    task t_unaligned;
        cfg_wr(8'h0C, 32'h0000_0008);
        run(64'h0000_0000_0000_1004, 16'h0008, 7'h08, 1'b0, 8'h02, 8'h00, 64'h0000_0000_0000_1020);
    endtask
    task t_disabled;
        cfg_wr(8'h04, 32'h0000_0000);
        run(64'h0000_0000_0000_4000, 16'h0008, 7'h08, 1'b0, 8'h01, 8'h00, 64'h0000_0000_0000_4000);
        cfg_wr(8'h04, 32'h0000_0010);
    endtask
    task t_dac;
        run(64'h0000_0001_0000_1000, 16'h0008, 7'h08, 1'b0, 8'h01, 8'h01, 64'h0000_0001_0000_1000);
    endtask
    // Two lines in one burst, a lapsed line end, and a target stop with resend
    task t_long;
        run(64'h0000_0000_0000_5000, 16'h0010, 7'h10, 1'b0, 8'h01, 8'h01, 64'h0000_0000_0000_5000);
        run(64'h0000_0000_0000_6000, 16'h000C, 7'h0C, 1'b0, 8'h02, 8'h01, 64'h0000_0000_0000_6020);
        m_stop = 1'b1;
        run(64'h0000_0000_0000_7000, 16'h0008, 7'h08, 1'b0, 8'h02, 8'h01, 64'h0000_0000_0000_701C);
        m_stop = 1'b0;
    endtask
    task test_done;
        if (n_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_core_clk);
        n_errors++;
        test_done;
    end
    initial begin
        {i_resetn, i_cfg_wr, i_cfg_rd, i_dma_start, m_slow, m_clr, m_stop} = 7'h00;
        {i_cfg_addr, i_cfg_wdata, i_dma_addr, i_dma_len, i_fifo_level} = '0;
        i_cfg_be = 4'h1;
        idx = 16'h0000;
        exp_idx = 16'h0000;
        n_errors = 0;
        checked = 0;
        repeat (6) @(posedge i_core_clk);
        #1;
        i_resetn = 1'b1;
        t_cfg;
        t_lines;
        t_unaligned;
        t_disabled;
        t_dac;
        t_long;
        test_done;
    end
endmodule
bind rdmwc_rx_dma_wr rdmwc_rx_dma_wr_sva rdmwc_rx_dma_wr_sva_i (.*);
